/* rtl/fpp_pkg.sv */
/*
 * constants, types and register map of the flash partition and protection block.
 * assumes a 10 MHz core clock and an apb master with 32-bit data.
 */
package fpp_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam int          PADDR_W  = 18;
	localparam logic [15:0] IDX_REV  = 16'h8005;
	localparam logic [15:0] IDX_PART = 16'h8006;
	localparam logic [15:0] IDX_CFG4 = 16'h800a;
	localparam logic [15:0] IDX_CFG5 = 16'h800b;
	localparam logic [15:0] IDX_CTRL = 16'h8010;
	localparam logic [15:0] IDX_STAT = 16'h8011;
	localparam logic [15:0] IDX_MAP  = 16'h8012;
	localparam logic [15:0] IDX_PC   = 16'h8013;

	// ------------------------------------------------------------
	// partition configuration word fields
	// ------------------------------------------------------------
	localparam int POS_LOW_VOLTAGE_PROGRAM_ENABLE  = 13;
	localparam int POS_STORAGE_AREA_WRITE_PROTECT_N = 11;
	localparam int POS_EEPROM_WRITE_PROTECT_N       = 10;
	localparam int POS_CONFIG_WRITE_PROTECT_N       = 9;
	localparam int POS_BOOT_WRITE_PROTECT_N         = 8;
	localparam int POS_APPLICATION_WRITE_PROTECT_N  = 7;
	localparam int POS_STORAGE_AREA_ENABLE_N        = 4;
	localparam int POS_BOOT_REGION_ENABLE_N         = 3;
	localparam int POS_BOOT_SIZE_SELECT             = 0;
	localparam logic [15:0] CFG4_RESET   = 16'h2f9f;
	localparam logic [15:0] CFG4_ONE_WAY = 16'h2f88;

	// code protection configuration word fields
	localparam int POS_EEPROM_READ_PROTECT_N  = 1;
	localparam int POS_PROGRAM_READ_PROTECT_N = 0;
	localparam logic [15:0] CFG5_RESET = 16'h0003;

	// identification words
	localparam logic [1:0] PART_FIXED_BITS = 2'b11;
	localparam logic [1:0] REV_FIXED_BITS  = 2'b10;

	// control and status bits
	localparam int POS_CTRL_BULK_ERASE    = 0;
	localparam int POS_STAT_WRITE_ERROR   = 0;
	localparam int POS_STAT_EXEC_VIOLATE  = 1;
	localparam int POS_STAT_LV_ACTIVE     = 2;

	// ------------------------------------------------------------
	// address map
	// ------------------------------------------------------------
	localparam logic [14:0] RESET_VECTOR   = 15'h0000;
	localparam logic [14:0] IRQ_VECTOR     = 15'h0004;
	localparam logic [14:0] PFM_LAST_SMALL = 15'h0fff;
	localparam logic [14:0] PFM_LAST_LARGE = 15'h1fff;
	localparam logic [14:0] BOOT_HALF_SMALL = 15'h07ff;
	localparam logic [14:0] BOOT_HALF_LARGE = 15'h0fff;
	localparam logic [14:0] STORE_SPAN_M1  = 15'h007f;
	localparam logic [14:0] BOOT_END_111   = 15'h01ff;
	localparam logic [14:0] BOOT_END_110   = 15'h03ff;
	localparam logic [14:0] BOOT_END_101   = 15'h07ff;
	localparam logic [14:0] BOOT_END_100   = 15'h0fff;
	localparam logic [14:0] BOOT_END_011   = 15'h1fff;
	localparam logic [14:0] BOOT_END_LOW   = 15'h3fff;
	localparam logic [15:0] CONFIG_FIRST   = 16'h8007;
	localparam logic [15:0] CONFIG_LAST    = 16'h800b;
	localparam logic [15:0] EEPROM_FIRST   = 16'hf000;
	localparam logic [15:0] EEPROM_LAST    = 16'hf0ff;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		REGION_NONE   = 3'b000,
		REGION_BOOT   = 3'b001,
		REGION_APP    = 3'b010,
		REGION_STORE  = 3'b011,
		REGION_CONFIG = 3'b100,
		REGION_EEPROM = 3'b101
	} fpp_region_t;

	typedef struct packed {
		logic [2:0] boot_size_select;
		logic       boot_region_enable_n;
		logic       storage_area_enable_n;
	} fpp_part_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} fpp_wr_req_t;

endpackage

/* rtl/fpp_region_decode.sv */
/*
 * address to region decoder for the partitioned flash map.
 * purely combinational; assumes the partition fields come from flops.
 */
`timescale 1ns/1ns
`default_nettype none

module fpp_region_decode
	import fpp_pkg::*;
(
	input  wire logic [15:0] addr_i,
	input  wire fpp_part_t   part_i,
	input  wire logic        large_i,
	output fpp_region_t      region_o,
	output logic      [14:0] boot_end_o,
	output logic      [14:0] store_first_o,
	output logic      [14:0] pfm_last_o
);
	logic [14:0] half;
	logic [14:0] raw_end;
	logic [14:0] wrapped;

	always_comb begin
		pfm_last_o  = large_i ? PFM_LAST_LARGE : PFM_LAST_SMALL;
		half        = large_i ? BOOT_HALF_LARGE : BOOT_HALF_SMALL;
		case (part_i.boot_size_select)
			3'b111:  raw_end = BOOT_END_111;
			3'b110:  raw_end = BOOT_END_110;
			3'b101:  raw_end = BOOT_END_101;
			3'b100:  raw_end = BOOT_END_100;
			3'b011:  raw_end = BOOT_END_011;
			default: raw_end = BOOT_END_LOW;
		endcase
		boot_end_o  = (raw_end > half) ? half : raw_end;
		store_first_o = pfm_last_o - STORE_SPAN_M1;
		wrapped     = addr_i[14:0] & pfm_last_o;
		if (!addr_i[15]) begin
			if (!part_i.boot_region_enable_n && wrapped <= boot_end_o) begin
				region_o = REGION_BOOT;
			end else if (!part_i.storage_area_enable_n && wrapped >= store_first_o) begin
				region_o = REGION_STORE;
			end else begin
				region_o = REGION_APP;
			end
		end else if (addr_i >= CONFIG_FIRST && addr_i <= CONFIG_LAST) begin
			region_o = REGION_CONFIG;
		end else if (addr_i >= EEPROM_FIRST && addr_i <= EEPROM_LAST) begin
			region_o = REGION_EEPROM;
		end else begin
			region_o = REGION_NONE;
		end
	end
endmodule

`default_nettype wire

/* rtl/fpp_sync3.sv */
/*
 * three-flop synchroniser for pins from outside the clock domain.
 * a new level is taken only once the second and third flops agree.
 */
`timescale 1ns/1ns
`default_nettype none

module fpp_sync3 #(
	parameter int W = 2
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			s1  <= '0;
			s2  <= '0;
			s3  <= '0;
			q_o <= '0;
		end else begin
			s1  <= d_i;
			s2  <= s1;
			s3  <= s2;
			// bits still settling keep their old value
			q_o <= (s2 & ~(s2 ^ s3)) | (q_o & (s2 ^ s3));
		end
	end
endmodule

`default_nettype wire

/* rtl/fpp_top.sv */
/*
 * flash partition and protection block: configuration words, id words,
 * region decode, write gating for the nonvolatile write controller and a
 * program counter model of the code space.
 * assumes an apb master on the core clock, a write controller on the same
 * clock and two asynchronous pins from the programming interface.
 */
// Notes on behaviour
// - storage area writes blocked when its protect clear
// - eeprom writes blocked when its protect clear
// - config words locked when config protect clear
// - boot writes blocked when boot protect clear
// - application writes blocked when its protect clear
// - storage area enabled when its bit is 0
// - boot block enabled when its bit is 0
// - size code selects boot block end address
// - boot block clamped to half of memory
// - size field frozen once boot block enabled
// - cleared protection returns only by bulk erase
// - low voltage enable not clearable while active
// - eeprom read protect active low, bit 1
// - program read protect active low, bit 0
// - code protection immediate, removed by bulk erase
// - part word read only, fixed upper bits
// - revision word read only, major and minor
// - program counter is fifteen bits wide
// - addresses beyond memory wrap, never fault
// - reset vector 0000h, interrupt vector 0004h
// - memory is 4096 or 8192 words
// - storage area is the last 128 words
// - protected write changes nothing, sets error flag
`timescale 1ns/1ns
`default_nettype none

module fpp_top
	import fpp_pkg::*;
#(
	parameter logic        LARGE_PFM  = 1'b1,
	parameter logic [11:0] PART_CODE  = 12'h5a5, // arbitrary
	parameter logic [5:0]  MAJOR_REV  = 6'h01,   // arbitrary
	parameter logic [5:0]  MINOR_REV  = 6'h02    // arbitrary
) (
	// clock and reset
	input  wire logic               CLK_I,
	input  wire logic               RSTN_I,
	// apb slave
	input  wire logic               PSEL_I,
	input  wire logic               PENABLE_I,
	input  wire logic               PWRITE_I,
	input  wire logic [PADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]        PWDATA_I,
	output logic      [31:0]        PRDATA_O,
	output logic                    PREADY_O,
	output logic                    PSLVERR_O,
	// nonvolatile write controller
	input  wire fpp_wr_req_t        NVM_WR_REQ_I,
	output logic                    NVM_WR_DONE_O,
	output logic                    NVM_WR_ERR_O,
	// programming interface pins
	input  wire logic               LV_PROG_ACTIVE_I,
	input  wire logic               BULK_ERASE_I,
	// program counter
	input  wire logic               PC_STEP_I,
	input  wire logic               PC_JUMP_I,
	input  wire logic [14:0]        PC_TARGET_I,
	input  wire logic               IRQ_TAKE_I,
	output logic      [14:0]        FETCH_ADDR_O,
	output logic                    EXEC_VIOLATION_O,
	// protection state
	output logic                    PROGRAM_READ_PROTECT_O,
	output logic                    EEPROM_READ_PROTECT_O,
	output logic                    LV_ENABLE_O
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0] cfg4;
	logic [15:0] cfg5;
	logic        write_error_flag;
	logic        exec_violation_flag;
	logic [14:0] pc;
	logic [1:0]  pins_sync;
	logic        bulk_pin_prev;

	logic [15:0] next_cfg4;
	logic [15:0] next_cfg5;
	logic [14:0] next_pc;
	logic [31:0] next_rdata;

	fpp_part_t   part;
	fpp_region_t wr_region;
	fpp_region_t fetch_region;
	logic [14:0] boot_end;
	logic [14:0] store_first;
	logic [14:0] pfm_last;

	logic        lv_active;
	logic        bulk_erase;
	logic        wr_blocked;
	logic        cfg_wr_blocked;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic [15:0] idx;
	logic        setup_ph;
	logic        access_ph;
	logic        hit;
	logic        wr_acc;

	assign idx       = PADDR_I[17:2];
	assign setup_ph  = PSEL_I & ~PENABLE_I;
	assign access_ph = PSEL_I & PENABLE_I;
	assign wr_acc    = access_ph & PWRITE_I & hit;

	always_comb begin
		case (idx)
			IDX_REV, IDX_PART, IDX_CFG4, IDX_CFG5, IDX_CTRL, IDX_STAT, IDX_MAP, IDX_PC: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// zero wait states: read data is captured in the setup cycle
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = access_ph & ~hit;

	// ------------------------------------------------------------
	// pins from the programming interface
	// ------------------------------------------------------------
	fpp_sync3 #(
		.W(2)
	) u_sync (
		.clk_i (CLK_I),
		.rstn_i(RSTN_I),
		.d_i   ({BULK_ERASE_I, LV_PROG_ACTIVE_I}),
		.q_o   (pins_sync)
	);

	assign lv_active = pins_sync[0];

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			bulk_pin_prev <= 1'b0;
		end else begin
			bulk_pin_prev <= pins_sync[1];
		end
	end

	// erase from the pin edge or from the control register
	assign bulk_erase = (pins_sync[1] & ~bulk_pin_prev) |
		(wr_acc & (idx == IDX_CTRL) & PWDATA_I[POS_CTRL_BULK_ERASE]);

	// ------------------------------------------------------------
	// region decode
	// ------------------------------------------------------------
	assign part.boot_size_select      = cfg4[POS_BOOT_SIZE_SELECT +: 3];
	assign part.boot_region_enable_n  = cfg4[POS_BOOT_REGION_ENABLE_N];
	assign part.storage_area_enable_n = cfg4[POS_STORAGE_AREA_ENABLE_N];

	// one decoder for write requests, one for the fetch address
	fpp_region_decode u_wr_decode (
		.addr_i     (NVM_WR_REQ_I.addr),
		.part_i     (part),
		.large_i    (LARGE_PFM),
		.region_o   (wr_region),
		.boot_end_o (boot_end),
		.store_first_o(store_first),
		.pfm_last_o (pfm_last)
	);

	fpp_region_decode u_fetch_decode (
		.addr_i     ({1'b0, pc}),
		.part_i     (part),
		.large_i    (LARGE_PFM),
		.region_o   (fetch_region),
		.boot_end_o (),
		.store_first_o(),
		.pfm_last_o ()
	);

	// ------------------------------------------------------------
	// write gating for the nonvolatile write controller
	// ------------------------------------------------------------
	// boot and storage regions only decode while enabled, so their
	// protect bits have no effect otherwise
	always_comb begin
		case (wr_region)
			REGION_BOOT:   wr_blocked = ~cfg4[POS_BOOT_WRITE_PROTECT_N];
			REGION_APP:    wr_blocked = ~cfg4[POS_APPLICATION_WRITE_PROTECT_N];
			REGION_STORE:  wr_blocked = ~cfg4[POS_STORAGE_AREA_WRITE_PROTECT_N];
			REGION_CONFIG: wr_blocked = ~cfg4[POS_CONFIG_WRITE_PROTECT_N];
			REGION_EEPROM: wr_blocked = ~cfg4[POS_EEPROM_WRITE_PROTECT_N];
			default:       wr_blocked = 1'b1;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			NVM_WR_DONE_O <= 1'b0;
			NVM_WR_ERR_O  <= 1'b0;
		end else begin
			NVM_WR_DONE_O <= NVM_WR_REQ_I.valid & ~wr_blocked;
			NVM_WR_ERR_O  <= NVM_WR_REQ_I.valid & wr_blocked;
		end
	end

	// ------------------------------------------------------------
	// configuration words
	// ------------------------------------------------------------
	assign cfg_wr_blocked = wr_acc & ~cfg4[POS_CONFIG_WRITE_PROTECT_N] &
		((idx == IDX_CFG4) | (idx == IDX_CFG5));

	always_comb begin
		next_cfg4 = cfg4;
		next_cfg5 = cfg5;
		if (bulk_erase) begin
			// erase wins over a write in the same cycle
			next_cfg4 = CFG4_RESET;
			next_cfg5 = CFG5_RESET;
		end else if (wr_acc && cfg4[POS_CONFIG_WRITE_PROTECT_N]) begin
			if (idx == IDX_CFG4) begin
				// one-way bits may only be cleared
				next_cfg4 = cfg4 & (PWDATA_I[15:0] | ~CFG4_ONE_WAY);
				next_cfg4[POS_STORAGE_AREA_ENABLE_N] = PWDATA_I[POS_STORAGE_AREA_ENABLE_N];
				if (lv_active) begin
					next_cfg4[POS_LOW_VOLTAGE_PROGRAM_ENABLE] = cfg4[POS_LOW_VOLTAGE_PROGRAM_ENABLE];
				end
				if (cfg4[POS_BOOT_REGION_ENABLE_N]) begin
					next_cfg4[POS_BOOT_SIZE_SELECT +: 3] = PWDATA_I[POS_BOOT_SIZE_SELECT +: 3];
				end else begin
					next_cfg4[POS_BOOT_SIZE_SELECT +: 3] = cfg4[POS_BOOT_SIZE_SELECT +: 3];
				end
			end else if (idx == IDX_CFG5) begin
				next_cfg5 = cfg5 & PWDATA_I[15:0];
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			cfg4 <= CFG4_RESET;
			cfg5 <= CFG5_RESET;
		end else begin
			cfg4 <= next_cfg4;
			cfg5 <= next_cfg5;
		end
	end

	// protection follows the stored word with no extra delay
	assign PROGRAM_READ_PROTECT_O = ~cfg5[POS_PROGRAM_READ_PROTECT_N];
	assign EEPROM_READ_PROTECT_O  = ~cfg5[POS_EEPROM_READ_PROTECT_N];
	assign LV_ENABLE_O            = cfg4[POS_LOW_VOLTAGE_PROGRAM_ENABLE];

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	// set wins over a write-one clear in the same cycle
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			write_error_flag <= 1'b0;
		end else if ((NVM_WR_REQ_I.valid & wr_blocked) | cfg_wr_blocked) begin
			write_error_flag <= 1'b1;
		end else if (wr_acc && idx == IDX_STAT && PWDATA_I[POS_STAT_WRITE_ERROR]) begin
			write_error_flag <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			exec_violation_flag <= 1'b0;
		end else if (fetch_region == REGION_STORE) begin
			exec_violation_flag <= 1'b1;
		end else if (wr_acc && idx == IDX_STAT && PWDATA_I[POS_STAT_EXEC_VIOLATE]) begin
			exec_violation_flag <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			EXEC_VIOLATION_O <= 1'b0;
		end else begin
			EXEC_VIOLATION_O <= (fetch_region == REGION_STORE);
		end
	end

	// ------------------------------------------------------------
	// program counter
	// ------------------------------------------------------------
	always_comb begin
		if (IRQ_TAKE_I) begin
			next_pc = IRQ_VECTOR;
		end else if (PC_JUMP_I) begin
			next_pc = PC_TARGET_I;
		end else if (PC_STEP_I) begin
			next_pc = pc + 15'h0001;
		end else begin
			next_pc = pc;
		end
	end

	// the stored value is already folded into the implemented space
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			pc <= RESET_VECTOR;
		end else begin
			pc <= next_pc & pfm_last;
		end
	end

	assign FETCH_ADDR_O = pc;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (idx)
			IDX_REV:  next_rdata[15:0] = {2'b00, REV_FIXED_BITS, MAJOR_REV, MINOR_REV};
			IDX_PART: next_rdata[15:0] = {2'b00, PART_FIXED_BITS, PART_CODE};
			IDX_CFG4: next_rdata[15:0] = cfg4;
			IDX_CFG5: next_rdata[15:0] = cfg5;
			IDX_STAT: begin
				next_rdata[POS_STAT_WRITE_ERROR]  = write_error_flag;
				next_rdata[POS_STAT_EXEC_VIOLATE] = exec_violation_flag;
				next_rdata[POS_STAT_LV_ACTIVE]    = lv_active;
			end
			IDX_MAP:  next_rdata = {1'b0, store_first, 1'b0, boot_end};
			IDX_PC:   next_rdata[14:0] = pc;
			default:  next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (setup_ph && !PWRITE_I) begin
			PRDATA_O <= next_rdata;
		end
	end

endmodule

`default_nettype wire

/* test/fpp_nvm_model.sv */
/*
 * nonvolatile write controller model: one-cycle write requests.
 * assumes the block answers one cycle after the request edge.
 */
`timescale 1ns/1ns
`default_nettype none

module fpp_nvm_model
	import fpp_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  done_i,
	input  wire logic  err_i,
	output var fpp_wr_req_t req_o
);
	initial req_o = '0;

	// res is {done, err}; address inverted once released so a stale value cannot match
	task automatic nvm_write(input logic [15:0] addr, output logic [1:0] res);
		@(posedge clk_i);
		req_o <= '{valid: 1'b1, addr: addr};
		@(posedge clk_i);
		req_o <= '{valid: 1'b0, addr: ~addr};
		@(negedge clk_i);
		res = {done_i, err_i};
	endtask
endmodule

`default_nettype wire

/* test/fpp_top_asserts.sv */
/*
 * checker for the flash partition and protection block.
 * sees only the top ports; attached by the bind at the foot of this file.
 */
`timescale 1ns/1ns
`default_nettype none

module fpp_chk
	import fpp_pkg::*;
#(
	parameter logic LARGE_PFM = 1'b1
) (
	input wire logic               CLK_I,
	input wire logic               RSTN_I,
	input wire logic               PSEL_I,
	input wire logic               PENABLE_I,
	input wire logic               PWRITE_I,
	input wire logic [PADDR_W-1:0] PADDR_I,
	input wire logic [31:0]        PWDATA_I,
	input wire logic [31:0]        PRDATA_O,
	input wire fpp_wr_req_t        NVM_WR_REQ_I,
	input wire logic               NVM_WR_DONE_O,
	input wire logic               NVM_WR_ERR_O,
	input wire logic               BULK_ERASE_I,
	input wire logic               PC_STEP_I,
	input wire logic               PC_JUMP_I,
	input wire logic [14:0]        PC_TARGET_I,
	input wire logic               IRQ_TAKE_I,
	input wire logic [14:0]        FETCH_ADDR_O,
	input wire logic               PROGRAM_READ_PROTECT_O,
	input wire logic               LV_ENABLE_O
);
	localparam logic [14:0] LAST = LARGE_PFM ? PFM_LAST_LARGE : PFM_LAST_SMALL;

	// ------------------------------------------------------------
	// erase window: pin erase lands a few edges late, so allow slack
	// ------------------------------------------------------------
	logic [3:0] erase_win;
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			erase_win <= 4'h0;
		end else if (BULK_ERASE_I || (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I[17:2] == IDX_CTRL && PWDATA_I[0])) begin
			erase_win <= 4'hf;
		end else if (erase_win != 4'h0) begin
			erase_win <= erase_win - 4'h1;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	property p_answer; NVM_WR_REQ_I.valid |=> (NVM_WR_DONE_O ^ NVM_WR_ERR_O); endproperty
	a_answer: assert property (p_answer) else $error("write request without single answer");
	property p_quiet; !NVM_WR_REQ_I.valid |=> !NVM_WR_DONE_O && !NVM_WR_ERR_O; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without request");
	property p_irq; IRQ_TAKE_I |=> FETCH_ADDR_O == IRQ_VECTOR; endproperty
	a_irq: assert property (p_irq) else $error("interrupt vector wrong");
	property p_jump; PC_JUMP_I && !IRQ_TAKE_I |=> FETCH_ADDR_O == ($past(PC_TARGET_I) & LAST); endproperty
	a_jump: assert property (p_jump) else $error("jump target not wrapped");
	property p_step; PC_STEP_I && !PC_JUMP_I && !IRQ_TAKE_I |=> FETCH_ADDR_O == (($past(FETCH_ADDR_O) + 15'h1) & LAST);
	endproperty
	a_step: assert property (p_step) else $error("step did not advance by one");
	property p_range; FETCH_ADDR_O <= LAST; endproperty
	a_range: assert property (p_range) else $error("fetch beyond implemented memory");
	property p_rp_sticky; $fell(PROGRAM_READ_PROTECT_O) |-> erase_win != 4'h0; endproperty
	a_rp_sticky: assert property (p_rp_sticky) else $error("code protection dropped without erase");
	property p_lv_sticky; $rose(LV_ENABLE_O) |-> erase_win != 4'h0; endproperty
	a_lv_sticky: assert property (p_lv_sticky) else $error("cleared bit set without erase");
	property p_hold; !(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O); endproperty
	a_hold: assert property (p_hold) else $error("read data moved outside read setup");
endmodule

bind fpp_top fpp_chk #(.LARGE_PFM(LARGE_PFM)) i_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.NVM_WR_REQ_I(NVM_WR_REQ_I), .NVM_WR_DONE_O(NVM_WR_DONE_O), .NVM_WR_ERR_O(NVM_WR_ERR_O),
	.BULK_ERASE_I(BULK_ERASE_I), .PC_STEP_I(PC_STEP_I), .PC_JUMP_I(PC_JUMP_I), .PC_TARGET_I(PC_TARGET_I),
	.IRQ_TAKE_I(IRQ_TAKE_I), .FETCH_ADDR_O(FETCH_ADDR_O), .PROGRAM_READ_PROTECT_O(PROGRAM_READ_PROTECT_O),
	.LV_ENABLE_O(LV_ENABLE_O));

`default_nettype wire

/* test/tb_top.sv */
/*
 * self-checking bench for the flash partition and protection block.
 * assumes the large memory variant and zero-wait apb answers.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top
	import fpp_pkg::*;
;
	localparam logic [11:0] PART = 12'h3c6; // arbitrary
	localparam logic [5:0]  MAJ  = 6'h05; // arbitrary
	localparam logic [5:0]  MIN  = 6'h09; // arbitrary

	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, se, done, err;
	logic        lv_act, erase_pin, step, jump, irq, viol, rp_prog, rp_ee, lv_en;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [14:0] target, fetch;
	logic [1:0]  r;
	fpp_wr_req_t req;
	int          fails, compares, cycles;

	fpp_top #(.LARGE_PFM(1'b1), .PART_CODE(PART), .MAJOR_REV(MAJ), .MINOR_REV(MIN)) i_dut (.CLK_I(clk),
		.RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .NVM_WR_REQ_I(req), .NVM_WR_DONE_O(done),
		.NVM_WR_ERR_O(err), .LV_PROG_ACTIVE_I(lv_act), .BULK_ERASE_I(erase_pin), .PC_STEP_I(step),
		.PC_JUMP_I(jump), .PC_TARGET_I(target), .IRQ_TAKE_I(irq), .FETCH_ADDR_O(fetch),
		.EXEC_VIOLATION_O(viol), .PROGRAM_READ_PROTECT_O(rp_prog), .EEPROM_READ_PROTECT_O(rp_ee),
		.LV_ENABLE_O(lv_en));
	fpp_nvm_model i_nvm (.clk_i(clk), .done_i(done), .err_i(err), .req_o(req));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic apb(input logic wr_n_rd, input logic [15:0] idx, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr_n_rd;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rdchk(input string n, input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(n, exp, rd);
	endtask
	task automatic nvm(input string n, input logic [15:0] a, input logic [1:0] exp);
		i_nvm.nvm_write(a, r);
		chk(n, {30'h0, exp}, {30'h0, r});
	endtask
	task automatic pc_op(input logic [2:0] sji, input logic [14:0] t, input logic [14:0] exp);
		@(posedge clk);
		{step, jump, irq} <= sji;
		target <= t;
		@(posedge clk);
		{step, jump, irq} <= 3'b000;
		@(negedge clk);
		chk("fetch", {17'h0, exp}, {17'h0, fetch});
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_ids();
		chk("reset fetch", 32'h0, {17'h0, fetch});
		rdchk("cfg4 reset", IDX_CFG4, 32'h2f9f);
		rdchk("cfg5 reset", IDX_CFG5, 32'h3);
		wr(IDX_PART, 32'h0);
		rdchk("part", IDX_PART, {18'h0, 2'b11, PART});
		wr(IDX_REV, 32'h0);
		rdchk("rev", IDX_REV, {18'h0, 2'b10, MAJ, MIN});
		apb(1'b0, 16'h8020, 32'h0);
		chk("unmapped", 32'h1, {31'h0, se});
	endtask
	task automatic t_boot();
		logic [14:0] e;
		for (int c = 0; c < 8; c++) begin
			e = (c == 7) ? 15'h01ff : (c == 6) ? 15'h03ff : (c == 5) ? 15'h07ff : 15'h0fff;
			wr(IDX_CTRL, 32'h1);
			wr(IDX_CFG4, 32'h2f90 | c);
			apb(1'b0, IDX_MAP, 32'h0);
			chk("boot end", {17'h0, e}, {17'h0, rd[14:0]});
		end
		wr(IDX_CFG4, 32'h2f90);
		rdchk("size frozen", IDX_CFG4, 32'h2f97);
		wr(IDX_CTRL, 32'h1);
		wr(IDX_CFG4, 32'h2f9a);
		rdchk("size free", IDX_CFG4, 32'h2f9a);
	endtask
	task automatic t_prot();
		logic [15:0] a[5] = '{16'h0100, 16'h0800, 16'h1f80, 16'hf000, 16'h8007};
		int          b[5] = '{8, 7, 11, 10, 9};
		for (int i = 0; i < 5; i++) begin
			wr(IDX_CTRL, 32'h1);
			wr(IDX_CFG4, 32'h2f87);
			nvm("open", a[i], 2'b10);
			wr(IDX_CFG4, 32'h2f87 & ~(32'h1 << b[i]));
			nvm("blocked", a[i], 2'b01);
			wr(IDX_CFG4, 32'h2f87);
			rdchk("one way", IDX_CFG4, 32'h2f87 & ~(32'h1 << b[i]));
			apb(1'b0, IDX_STAT, 32'h0);
			chk("write error", 32'h1, {31'h0, rd[0]});
		end
		wr(IDX_CFG5, 32'h0);
		rdchk("cfg locked", IDX_CFG5, 32'h3);
		nvm("unmapped", 16'h9000, 2'b01);
		wr(IDX_CTRL, 32'h1);
		wr(IDX_CFG4, 32'h269f);
		nvm("store off", 16'h1f80, 2'b10);
		nvm("boot off", 16'h0100, 2'b10);
	endtask
	task automatic t_rd_prot();
		wr(IDX_CFG5, 32'h2);
		@(negedge clk);
		chk("prog protect", 32'h1, {31'h0, rp_prog});
		chk("ee open", 32'h0, {31'h0, rp_ee});
		wr(IDX_CFG5, 32'h1);
		@(negedge clk);
		chk("ee protect", 32'h1, {31'h0, rp_ee});
		wr(IDX_CFG5, 32'h3);
		rdchk("rp sticky", IDX_CFG5, 32'h0);
		lv_act <= 1'b1;
		repeat (6) @(posedge clk);
		wr(IDX_CFG4, 32'h0f9f);
		rdchk("lv kept", IDX_CFG4, 32'h269f);
		lv_act <= 1'b0;
		repeat (6) @(posedge clk);
		wr(IDX_CFG4, 32'h0f9f);
		rdchk("lv cleared", IDX_CFG4, 32'h069f);
		erase_pin <= 1'b1;
		repeat (8) @(posedge clk);
		erase_pin <= 1'b0;
		repeat (8) @(posedge clk);
		rdchk("erase cfg5", IDX_CFG5, 32'h3);
		rdchk("erase cfg4", IDX_CFG4, 32'h2f9f);
	endtask
	task automatic t_pc();
		pc_op(3'b001, 15'h0000, 15'h0004);
		pc_op(3'b010, 15'h7ffe, 15'h1ffe);
		pc_op(3'b100, 15'h0000, 15'h1fff);
		pc_op(3'b100, 15'h0000, 15'h0000);
		pc_op(3'b011, 15'h0100, 15'h0004);
		wr(IDX_CFG4, 32'h2f8f);
		pc_op(3'b010, 15'h1f7f, 15'h1f7f);
		@(negedge clk);
		chk("no violation", 32'h0, {31'h0, viol});
		pc_op(3'b010, 15'h1f80, 15'h1f80);
		@(negedge clk);
		chk("violation", 32'h1, {31'h0, viol});
	endtask

	// ------------------------------------------------------------
	// clock, timeout and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		{rstn, psel, penable, pwrite, lv_act, erase_pin, step, jump, irq} = '0;
		paddr = '0;
		pwdata = '0;
		target = '0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_ids();
		t_boot();
		t_prot();
		t_rd_prot();
		t_pc();
		end_of_test();
	end
endmodule

`default_nettype wire
